// file: mhp_pkg.sv
// Package holding register map, field positions, reset values and shared types of the host port.
package mhp_pkg;

  // Register select codes of the seven host registers; code 3'h6 is unused.
  localparam logic [2:0] REG_RAM_DATA_LOW = 3'h0;
  localparam logic [2:0] REG_RAM_DATA_HIGH = 3'h1;
  localparam logic [2:0] REG_RAM_ADDRESS_LOW = 3'h2;
  localparam logic [2:0] REG_PARALLEL_DATA = 3'h3;
  localparam logic [2:0] REG_RAM_CONTROL = 3'h4;
  localparam logic [2:0] REG_PUMP_STATUS = 3'h5;
  localparam logic [2:0] REG_FRAME_STATUS = 3'h7;

  // Bit positions inside the RAM control register.
  localparam int CTL_ADDR_MSB = 0;
  localparam int CTL_ACCESS_REQ = 1;
  localparam int CTL_WRITE_SEL = 2;
  localparam int CTL_SOFT_SEND = 3;
  localparam int CTL_PARALLEL = 4;
  localparam int CTL_RAM_IE = 5;
  localparam int CTL_RX_IE = 6;
  localparam int CTL_TX_IE = 7;

  // Values after reset.
  localparam logic [7:0] RST_RAM_CONTROL = 8'h00;
  localparam logic [7:0] RST_DATA_BYTE = 8'h00;
  localparam logic [7:0] RST_ZERO_BYTE = 8'h00;

  // Depth of the synchroniser on every pin input.
  localparam int SYNC_STAGES = 3;

  // Host bus pins as one bundle; all are sampled through the synchroniser.
  typedef struct packed {
    logic cs_n;        // Chip select, active low.
    logic rd_n;        // Read strobe, active low.
    logic wr_n;        // Write strobe, active low.
    logic rts_n;       // Hardware request to send, active low.
    logic [2:0] sel;   // Register select.
    logic [7:0] data;  // Data bus as seen on the pins.
  } mhp_pins_s;

  // Status levels that the pump core reports on the same clock.
  typedef struct packed {
    logic in_reset_flag;         // Pump still in its reset cycle.
    logic carrier_present;       // Carrier detected.
    logic retrain_seen;          // Retrain sequence detected.
    logic pump_transmit_active;  // Pump busy sending.
    logic standby;               // Operating mode field is zero.
    logic frame_transmit_done;   // Frame sent.
    logic frame_receive_error;   // Frame received with error.
    logic frame_end;             // End of received frame.
  } mhp_pump_s;

  // RAM access sequencer states.
  typedef enum logic [0:0] {
    RAM_IDLE = 1'b0,
    RAM_WAIT = 1'b1
  } mhp_ram_state_e;

endpackage : mhp_pkg

// file: mhp_buffer.sv
// Two-entry valid/ready buffer that carries transmit bytes from the host to the pump.
`timescale 1ns/1ps
module mhp_buffer import mhp_pkg::*; #(
  parameter int WIDTH = 8,  // Width of one word.
  parameter int DEPTH = 2   // Number of entries.
) (
  input wire logic sys_clk,                // System clock.
  input wire logic reset_n,                // Asynchronous reset, active low.
  input wire logic in_valid,               // Word offered by the filling side.
  output logic in_ready,                   // Room for a word.
  input wire logic [WIDTH-1:0] in_data,    // Word being offered.
  output logic out_valid,                  // Word available to the drain.
  input wire logic out_ready,              // Drain takes the word.
  output logic [WIDTH-1:0] out_data        // Oldest stored word.
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];  // Storage array.
  logic [PW-1:0] wr_ptr_ff;          // Next entry to fill.
  logic [PW-1:0] rd_ptr_ff;          // Oldest entry.
  logic [PW:0] count_ff;             // Entries in use.
  logic push;                        // Word accepted this cycle.
  logic pop;                         // Word drained this cycle.

  // Wrap a pointer back to zero after the last entry.
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] ptr);
    bump = (ptr == PW'(DEPTH - 1)) ? '0 : ptr + PW'(1);
  endfunction : bump

  assign in_ready = (count_ff != (PW + 1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage itself needs no reset; the count tells which entries are real.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= bump(wr_ptr_ff);
      if (pop) rd_ptr_ff <= bump(rd_ptr_ff);
      count_ff <= count_ff + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end

endmodule : mhp_buffer

// file: mhp_host_port.sv
// Host register port of the modem pump: byte registers, RAM access sequencer and data path.
`timescale 1ns/1ps
module mhp_host_port import mhp_pkg::*; #(
  parameter logic [7:0] FW_VERSION = 8'h5A  // Firmware version; value is arbitrary.
) (
  input wire logic sys_clk,                 // System clock, 125 MHz.
  input wire logic reset_n,                 // Asynchronous reset, active low.
  input wire logic hcs_n,                   // Host chip select pin.
  input wire logic hrd_n,                   // Host read strobe pin.
  input wire logic hwr_n,                   // Host write strobe pin.
  input wire logic [2:0] register_select,   // Host register select pins.
  input wire logic [7:0] hd_in,             // Host data bus, pin level.
  output logic [7:0] hd_out,                // Host data bus, driven value.
  output logic hd_oe,                       // Host data bus drive enable.
  output logic host_irq_pin_n,              // Host interrupt, active low.
  input wire logic rts_n,                   // Request-to-send pin, active low.
  output logic send_request,                // Combined transmit request.
  output logic parallel_transfer_select,    // Line data uses parallel path.
  input wire mhp_pump_s pump_status_in,     // Status levels from the pump core.
  output logic ram_req,                     // RAM access request to the core.
  output logic ram_write,                   // Access is a write.
  output logic [8:0] ram_addr,              // RAM word address.
  output logic [15:0] ram_wdata,            // Word to write.
  input wire logic ram_ack,                 // Core finished the access.
  input wire logic [15:0] ram_rdata,        // Word read, valid with ram_ack.
  output logic tx_valid,                    // Transmit byte offered to the core.
  input wire logic tx_ready,                // Core takes the transmit byte.
  output logic [7:0] tx_data,               // Transmit byte.
  input wire logic rx_valid,                // Core offers a received byte.
  output logic rx_ready,                    // Port accepts received bytes.
  input wire logic [7:0] rx_data            // Received byte.
);

  // Three-stage pin synchroniser and the filtered level behind it.
  mhp_pins_s pin_raw;
  mhp_pins_s sync1_ff;   // First stage, read only by the second.
  mhp_pins_s sync2_ff;   // Second stage.
  mhp_pins_s sync3_ff;   // Third stage.
  mhp_pins_s pin_ff;     // Level accepted once stages two and three agree.
  mhp_pins_s nxt_pin;

  assign pin_raw = '{cs_n: hcs_n, rd_n: hrd_n, wr_n: hwr_n, rts_n: rts_n,
                     sel: register_select, data: hd_in};
  // A bit moves only when the last two stages agree, which rejects single-cycle glitches.
  assign nxt_pin = (sync2_ff & sync3_ff) | (pin_ff & (sync2_ff ^ sync3_ff));

  // Synchroniser chain.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= '1;
      sync2_ff <= '1;
      sync3_ff <= '1;
      pin_ff <= '1;
    end else begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      pin_ff <= nxt_pin;
    end
  end

  // Strobe decode from the filtered pins.
  logic wr_act;          // Write cycle in progress.
  logic rd_act;          // Read cycle in progress.
  logic wr_act_d_ff;     // Write cycle one clock ago.
  logic rd_act_d_ff;     // Read cycle one clock ago.
  logic [2:0] rd_sel_ff; // Register being read.
  logic wr_take;         // First clock of a write cycle.
  logic rd_end;          // Last clock of a read cycle has passed.

  assign wr_act = ~pin_ff.cs_n & ~pin_ff.wr_n;
  assign rd_act = ~pin_ff.cs_n & ~pin_ff.rd_n & pin_ff.wr_n;
  assign wr_take = wr_act & ~wr_act_d_ff;
  assign rd_end = rd_act_d_ff & ~rd_act;

  // Register writes, one per host write cycle, taken at its start.
  logic wr_data_low;
  logic wr_data_high;
  logic wr_addr_low;
  logic wr_parallel;
  logic wr_control;
  logic rd_parallel_done;
  logic rd_status_done;

  assign wr_data_low = wr_take & (pin_ff.sel == REG_RAM_DATA_LOW);
  assign wr_data_high = wr_take & (pin_ff.sel == REG_RAM_DATA_HIGH);
  assign wr_addr_low = wr_take & (pin_ff.sel == REG_RAM_ADDRESS_LOW);
  assign wr_parallel = wr_take & (pin_ff.sel == REG_PARALLEL_DATA);
  assign wr_control = wr_take & (pin_ff.sel == REG_RAM_CONTROL);
  assign rd_parallel_done = rd_end & (rd_sel_ff == REG_PARALLEL_DATA);
  assign rd_status_done = rd_end & (rd_sel_ff == REG_PUMP_STATUS);

  // Register storage.
  logic [7:0] data_low_ff;       // RAM data low byte.
  logic [7:0] data_high_ff;      // RAM data high byte.
  logic [7:0] addr_low_ff;       // RAM address low byte.
  logic [7:0] parallel_rx_ff;    // Byte the host reads from the parallel register.
  logic [7:0] control_ff;        // RAM control register.
  logic ram_done_flag_ff;        // Access finished.
  logic receive_flag_ff;         // New received byte waiting.
  logic transmit_flag_ff;        // Pump took a transmit byte.
  mhp_ram_state_e ram_state_ff;  // Access sequencer state.
  logic ram_req_ff;
  logic ram_write_ff;
  logic [8:0] ram_addr_ff;
  logic [15:0] ram_wdata_ff;
  logic send_request_ff;
  logic rx_ready_ff;
  logic host_irq_pin_n_ff;
  logic [7:0] hd_out_ff;
  logic hd_oe_ff;

  // Data path decode.
  logic parallel_mode;   // Parallel transfer selected.
  logic ram_start;       // Sequencer launches an access.
  logic ram_finish;      // Core answers the access.
  logic rx_take;         // Received byte lands in the parallel register.
  logic tx_push_ready;   // Buffer has room for a host byte.
  logic tx_taken;        // Core takes a byte from the buffer.
  logic irq_any;         // Some enabled flag is set; receive and transmit flags count in parallel mode only.

  assign parallel_mode = control_ff[CTL_PARALLEL];
  assign ram_start = (ram_state_ff == RAM_IDLE) & control_ff[CTL_ACCESS_REQ];
  assign ram_finish = (ram_state_ff == RAM_WAIT) & ram_ack;
  assign rx_take = rx_valid & rx_ready_ff;
  assign tx_taken = tx_valid & tx_ready;
  assign irq_any = (ram_done_flag_ff & control_ff[CTL_RAM_IE])
                 | (parallel_mode & receive_flag_ff & control_ff[CTL_RX_IE])
                 | (parallel_mode & transmit_flag_ff & control_ff[CTL_TX_IE]);

  // Transmit bytes queue here so a slow pump can fall up to two bytes behind; a write while full is dropped.
  mhp_buffer #(.WIDTH(8), .DEPTH(2)) u_tx_buffer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(wr_parallel & parallel_mode),
    .in_ready(tx_push_ready),
    .in_data(pin_ff.data),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );

  // Read multiplexer; write-only and unused codes read as zero.
  logic [7:0] status_byte;
  logic [7:0] frame_byte;
  logic [7:0] read_byte;

  assign status_byte = {transmit_flag_ff, receive_flag_ff, ram_done_flag_ff,
                        pump_status_in.pump_transmit_active, 1'b0,
                        pump_status_in.retrain_seen, pump_status_in.carrier_present,
                        pump_status_in.in_reset_flag};
  assign frame_byte = {5'h00, pump_status_in.frame_transmit_done,
                       pump_status_in.frame_receive_error, pump_status_in.frame_end};
  assign read_byte = (pin_ff.sel == REG_RAM_DATA_LOW) ? data_low_ff :
                     (pin_ff.sel == REG_RAM_DATA_HIGH) ? data_high_ff :
                     (pin_ff.sel == REG_PARALLEL_DATA) ? parallel_rx_ff :
                     (pin_ff.sel == REG_RAM_CONTROL) ? control_ff :
                     (pin_ff.sel == REG_PUMP_STATUS) ? status_byte :
                     (pin_ff.sel == REG_FRAME_STATUS) ? frame_byte : RST_ZERO_BYTE;

  // Bus drive: data follows the selected register for the whole read cycle.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_act_d_ff <= 1'b0;
      rd_act_d_ff <= 1'b0;
      rd_sel_ff <= 3'h0;
      hd_out_ff <= RST_ZERO_BYTE;
      hd_oe_ff <= 1'b0;
    end else begin
      wr_act_d_ff <= wr_act;
      rd_act_d_ff <= rd_act;
      if (rd_act) rd_sel_ff <= pin_ff.sel;
      hd_out_ff <= rd_act ? read_byte : RST_ZERO_BYTE;
      hd_oe_ff <= rd_act;
    end
  end

  // RAM data registers: a finished read overwrites any host write in the same clock.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_low_ff <= RST_DATA_BYTE;
      data_high_ff <= RST_DATA_BYTE;
      addr_low_ff <= RST_DATA_BYTE;
    end else begin
      if (ram_finish & ~ram_write_ff) begin
        data_low_ff <= ram_rdata[7:0];
        data_high_ff <= ram_rdata[15:8];
      end else begin
        if (wr_data_low) data_low_ff <= pin_ff.data;
        if (wr_data_high) data_high_ff <= pin_ff.data;
      end
      if (wr_addr_low) addr_low_ff <= pin_ff.data;
    end
  end

  // Control register; completion clears the request bit even over a host write.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      control_ff <= RST_RAM_CONTROL;
    end else if (ram_finish) begin
      control_ff <= (wr_control ? pin_ff.data : control_ff)
                    & ~(8'h01 << CTL_ACCESS_REQ);
    end else if (wr_control) begin
      control_ff <= pin_ff.data;
    end
  end

  // Access sequencer: latches address, direction and data at launch, then waits for the core.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ram_state_ff <= RAM_IDLE;
      ram_req_ff <= 1'b0;
      ram_write_ff <= 1'b0;
      ram_addr_ff <= 9'h000;
      ram_wdata_ff <= 16'h0000;
    end else begin
      case (ram_state_ff)
        RAM_IDLE: begin
          if (ram_start) begin
            ram_state_ff <= RAM_WAIT;
            ram_req_ff <= 1'b1;
            ram_write_ff <= control_ff[CTL_WRITE_SEL];
            ram_addr_ff <= {control_ff[CTL_ADDR_MSB], addr_low_ff};
            ram_wdata_ff <= {data_high_ff, data_low_ff};
          end
        end
        RAM_WAIT: begin
          if (ram_ack) begin
            ram_state_ff <= RAM_IDLE;
            ram_req_ff <= 1'b0;
          end
        end
        default: begin
          ram_state_ff <= RAM_IDLE;
          ram_req_ff <= 1'b0;
        end
      endcase
    end
  end

  // Flags: in every flag a set in the same clock as a clear wins.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ram_done_flag_ff <= 1'b0;
      receive_flag_ff <= 1'b0;
      transmit_flag_ff <= 1'b0;
    end else begin
      ram_done_flag_ff <= ram_finish | (ram_done_flag_ff & ~rd_status_done);
      receive_flag_ff <= rx_take | (receive_flag_ff & ~rd_parallel_done);
      transmit_flag_ff <= (tx_taken & parallel_mode)
                          | (transmit_flag_ff & ~wr_parallel);
    end
  end

  // Parallel register: version after reset and in standby, else received bytes.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      parallel_rx_ff <= FW_VERSION;
    end else if (pump_status_in.standby) begin
      parallel_rx_ff <= FW_VERSION;
    end else if (rx_take) begin
      parallel_rx_ff <= rx_data;
    end
  end

  // Outgoing levels, all registered.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      send_request_ff <= 1'b0;
      rx_ready_ff <= 1'b0;
      host_irq_pin_n_ff <= 1'b1;
    end else begin
      // The pin source is active low; the host is expected to idle the unused source.
      send_request_ff <= control_ff[CTL_SOFT_SEND] | ~pin_ff.rts_n;
      rx_ready_ff <= parallel_mode & ~pump_status_in.standby;
      host_irq_pin_n_ff <= ~irq_any;
    end
  end

  assign hd_out = hd_out_ff;
  assign hd_oe = hd_oe_ff;
  assign host_irq_pin_n = host_irq_pin_n_ff;
  assign send_request = send_request_ff;
  assign parallel_transfer_select = control_ff[CTL_PARALLEL];
  assign ram_req = ram_req_ff;
  assign ram_write = ram_write_ff;
  assign ram_addr = ram_addr_ff;
  assign ram_wdata = ram_wdata_ff;
  assign rx_ready = rx_ready_ff;

  // Checks on the port's own behaviour.
  sequence s_ram_launch;
    (ram_state_ff == RAM_IDLE) && control_ff[CTL_ACCESS_REQ];
  endsequence

  sequence s_ram_answer;
    (ram_state_ff == RAM_WAIT) && ram_ack;
  endsequence

  property p_launch_address;
    @(posedge sys_clk) disable iff (!reset_n)
    s_ram_launch |=> ram_req_ff && (ram_addr_ff == {$past(control_ff[0]), $past(addr_low_ff)})
                     && (ram_write_ff == $past(control_ff[2]));
  endproperty
  a_launch_address: assert property (p_launch_address) else $error("Bad launch");

  property p_write_pair;
    @(posedge sys_clk) disable iff (!reset_n)
    s_ram_launch |=> ram_wdata_ff == {$past(data_high_ff), $past(data_low_ff)};
  endproperty
  a_write_pair: assert property (p_write_pair) else $error("RAM write data wrong");

  property p_done_clears_request;
    @(posedge sys_clk) disable iff (!reset_n)
    s_ram_answer |=> ram_done_flag_ff && !control_ff[1] && !ram_req_ff;
  endproperty
  a_done_clears_request: assert property (p_done_clears_request)
    else $error("Completion not seen");

  property p_read_result;
    @(posedge sys_clk) disable iff (!reset_n)
    s_ram_answer ##0 !ram_write_ff |=> {data_high_ff, data_low_ff} == $past(ram_rdata);
  endproperty
  a_read_result: assert property (p_read_result) else $error("Read result not loaded");

  property p_send_or;
    @(posedge sys_clk) disable iff (!reset_n)
    1'b1 |=> send_request_ff == ($past(control_ff[3]) | !$past(pin_ff.rts_n));
  endproperty
  a_send_or: assert property (p_send_or) else $error("Send request not combined");

  property p_irq_level;
    @(posedge sys_clk) disable iff (!reset_n)
    // Completion also clears the request bit, so the control byte changes here unless the host cleared that bit during the wait.
    $rose(ram_done_flag_ff) && control_ff[CTL_RAM_IE] |=> !host_irq_pin_n_ff;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("No interrupt");

  property p_standby_version;
    @(posedge sys_clk) disable iff (!reset_n)
    pump_status_in.standby |=> parallel_rx_ff == FW_VERSION;
  endproperty
  a_standby_version: assert property (p_standby_version) else $error("No version");

  property p_receive_flag;
    @(posedge sys_clk) disable iff (!reset_n)
    rx_valid && rx_ready_ff && !pump_status_in.standby
      |=> receive_flag_ff && parallel_rx_ff == $past(rx_data);
  endproperty
  a_receive_flag: assert property (p_receive_flag) else $error("Receive not flagged");

  property p_transmit_flag;
    @(posedge sys_clk) disable iff (!reset_n)
    tx_valid && tx_ready && parallel_mode |=> transmit_flag_ff;
  endproperty
  a_transmit_flag: assert property (p_transmit_flag) else $error("Take not flagged");

  // A full queue with a stalled pump must keep its oldest byte; a late host write is dropped.
  property p_full_holds;
    @(posedge sys_clk) disable iff (!reset_n)
    !tx_push_ready && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_full_holds: assert property (p_full_holds) else $error("Full buffer moved");

  property p_drive_only_reading;
    @(posedge sys_clk) disable iff (!reset_n)
    hd_oe_ff |-> $past(rd_act) && $past(pin_ff.sel) != 3'h6 || hd_out_ff == 8'h00;
  endproperty
  a_drive_only_reading: assert property (p_drive_only_reading)
    else $error("Bus driven outside read");

endmodule : mhp_host_port

// file: mhp_core_model.sv
// Behavioural pump core that answers RAM requests and drains transmit bytes.
`timescale 1ns/1ps
module mhp_core_model (
  input wire logic sys_clk, // Clock.
  input wire logic reset_n, // Reset, active low.
  input wire logic ram_req, // Access request.
  input wire logic ram_write, // Access is a write.
  input wire logic [8:0] ram_addr, // Word address.
  input wire logic [15:0] ram_wdata, // Word to store.
  output logic ram_ack, // One-cycle completion pulse.
  output logic [15:0] ram_rdata, // Read word, valid with ram_ack only.
  input wire logic stall, // Bench holds transmit drain off.
  output logic tx_ready // Core takes transmit bytes.
);
  logic [15:0] mem [512]; // Pump RAM image.
  logic [1:0] wait_ff; // Slow answer, three clocks per access.
  // Outside the ack cycle read data toggles so stale values never match.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_ff <= 2'h0;
      ram_ack <= 1'b0;
      ram_rdata <= 16'h0000;
    end else begin
      ram_ack <= 1'b0;
      ram_rdata <= ~ram_rdata;
      if (ram_req && !ram_ack && wait_ff == 2'h2) begin
        ram_ack <= 1'b1;
        wait_ff <= 2'h0;
        if (ram_write) mem[ram_addr] <= ram_wdata;
        else ram_rdata <= mem[ram_addr];
      end else if (ram_req && !ram_ack) wait_ff <= wait_ff + 2'h1;
    end
  end
  assign tx_ready = reset_n && !stall;
endmodule : mhp_core_model

// file: tb_mhp_host_port.sv
// Self-checking testbench of the modem pump host register port.
`timescale 1ns/1ps
module tb_mhp_host_port import mhp_pkg::*;;
  logic sys_clk = 0, reset_n = 0, hcs_n = 1, hrd_n = 1, hwr_n = 1, rts_n = 1;
  logic rx_valid = 0, stall = 0;
  logic [2:0] sel = 3'h0;
  logic [7:0] hbus = 8'h00, rx_data = 8'h00, q;
  mhp_pump_s pst = '0;
  wire logic [7:0] hd_in, hd_out, tx_data;
  wire logic hd_oe, irq_n, snd, pts, ram_req, ram_write, ram_ack, tx_valid, tx_ready, rx_ready;
  wire logic [8:0] ram_addr;
  wire logic [15:0] ram_wdata, ram_rdata;
  int num_errors = 0, num_checks = 0, cyc = 0;
  always #4 sys_clk = ~sys_clk;
  // The shared bus carries the port's byte while it drives.
  assign hd_in = hd_oe ? hd_out : hbus;
  mhp_host_port dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .hcs_n(hcs_n), .hrd_n(hrd_n),
    .hwr_n(hwr_n), .register_select(sel), .hd_in(hd_in), .hd_out(hd_out), .hd_oe(hd_oe),
    .host_irq_pin_n(irq_n), .rts_n(rts_n), .send_request(snd),
    .parallel_transfer_select(pts), .pump_status_in(pst), .ram_req(ram_req),
    .ram_write(ram_write), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_ack(ram_ack),
    .ram_rdata(ram_rdata), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));
  mhp_core_model core_u (.sys_clk(sys_clk), .reset_n(reset_n), .ram_req(ram_req),
    .ram_write(ram_write), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_ack(ram_ack),
    .ram_rdata(ram_rdata), .stall(stall), .tx_ready(tx_ready));
  task end_of_test;
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task chk(input string n, input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Strobes stay low and high six clocks, past the three-flop synchroniser.
  task wr(input logic [2:0] a, input logic [7:0] d);
    sel = a;
    hbus = d;
    hcs_n = 0;
    hwr_n = 0;
    repeat (6) @(negedge sys_clk);
    hcs_n = 1;
    hwr_n = 1;
    repeat (6) @(negedge sys_clk);
  endtask : wr
  // The byte is taken while the port still drives it, before the strobes rise.
  task rd(input logic [2:0] a, output logic [7:0] d);
    sel = a;
    hcs_n = 0;
    hrd_n = 0;
    repeat (8) @(negedge sys_clk);
    d = hd_out;
    chk("drive", {7'h0, hd_oe}, 8'h01);
    hcs_n = 1;
    hrd_n = 1;
    repeat (6) @(negedge sys_clk);
  endtask : rd
  // Values after reset, the unused code and the read-only frame view.
  task t_reset;
    pst.frame_end = 1;
    rd(REG_RAM_CONTROL, q);
    chk("control", q, 8'h00);
    rd(REG_PARALLEL_DATA, q);
    chk("version", q, 8'h5A);
    rd(3'h6, q);
    chk("unused", q, 8'h00);
    rd(REG_FRAME_STATUS, q);
    chk("frame", q, 8'h01);
    pst.frame_end = 0;
  endtask : t_reset
  // Write 1234 to address 105, then read it back over a dirtied data pair.
  task t_ram;
    wr(REG_RAM_DATA_LOW, 8'h34);
    wr(REG_RAM_DATA_HIGH, 8'h12);
    wr(REG_RAM_ADDRESS_LOW, 8'h05);
    wr(REG_RAM_CONTROL, 8'h27);
    rd(REG_RAM_CONTROL, q);
    chk("req clear", q, 8'h25);
    chk("irq", {7'h0, irq_n}, 8'h00);
    rd(REG_PUMP_STATUS, q);
    chk("ram done", q, 8'h20);
    wr(REG_RAM_DATA_LOW, 8'hFF);
    wr(REG_RAM_DATA_HIGH, 8'hFF);
    // Request bit with direction zero: a read of the same high location.
    wr(REG_RAM_CONTROL, 8'h03);
    rd(REG_RAM_DATA_LOW, q);
    chk("rd low", q, 8'h34);
    rd(REG_RAM_DATA_HIGH, q);
    chk("rd high", q, 8'h12);
    chk("irq off", {7'h0, irq_n}, 8'h01);
  endtask : t_ram
  // All four pairings of the soft bit and the pin.
  task t_send;
    for (int i = 0; i < 4; i++) begin
      wr(REG_RAM_CONTROL, {4'h0, i[0], 3'h0});
      rts_n = i[1];
      repeat (6) @(negedge sys_clk);
      chk("send", {7'h0, snd}, {7'h0, i[0] | !i[1]});
    end
    rts_n = 1;
  endtask : t_send
  // Receive one byte, then fill the buffer past full with the drain stalled.
  task t_par;
    wr(REG_RAM_CONTROL, 8'hD0);
    chk("mode", {7'h0, pts}, 8'h01);
    chk("rx ready", {7'h0, rx_ready}, 8'h01);
    rx_data = 8'hA5;
    rx_valid = 1;
    @(negedge sys_clk);
    rx_valid = 0;
    repeat (2) @(negedge sys_clk);
    chk("rx irq", {7'h0, irq_n}, 8'h00);
    rd(REG_PARALLEL_DATA, q);
    chk("rx byte", q, 8'hA5);
    // The done flag of the last RAM read is still up; only the receive flag drops.
    rd(REG_PUMP_STATUS, q);
    chk("rx flag", q, 8'h20);
    stall = 1;
    wr(REG_PARALLEL_DATA, 8'h11);
    wr(REG_PARALLEL_DATA, 8'h22);
    wr(REG_PARALLEL_DATA, 8'h33);
    chk("tx 1st", tx_data, 8'h11);
    chk("tx no irq", {7'h0, irq_n}, 8'h01);
    stall = 0;
    @(negedge sys_clk);
    chk("tx 2nd", tx_data, 8'h22);
    @(negedge sys_clk);
    chk("tx empty", {7'h0, tx_valid}, 8'h00);
    repeat (2) @(negedge sys_clk);
    chk("tx irq", {7'h0, irq_n}, 8'h00);
    rd(REG_PUMP_STATUS, q);
    chk("tx flag", q, 8'h80);
  endtask : t_par
  // A second reset in mid-run clears control and brings the version back.
  task t_rerun;
    reset_n = 0;
    repeat (2) @(negedge sys_clk);
    reset_n = 1;
    repeat (4) @(negedge sys_clk);
    rd(REG_RAM_CONTROL, q);
    chk("control again", q, 8'h00);
    rd(REG_PARALLEL_DATA, q);
    chk("version again", q, 8'h5A);
  endtask : t_rerun
  // Standby puts the version back into the parallel register.
  task t_standby;
    pst.standby = 1;
    repeat (8) @(negedge sys_clk);
    rd(REG_PARALLEL_DATA, q);
    chk("standby", q, 8'h5A);
  endtask : t_standby
  // Cycle ceiling far above the roughly 430 clocks the scenarios need.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test;
    end
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    reset_n = 1;
    repeat (4) @(negedge sys_clk);
    t_reset;
    t_ram;
    t_send;
    t_par;
    t_rerun;
    t_standby;
    end_of_test;
  end
endmodule : tb_mhp_host_port
